// file: src/srr_pkg.sv
// Purpose: Shared constants for the sensor status readback registers
// Assumes: 8-bit register port, 20 MHz system clock
// Notes:   Test and timing figures are named once here
package srr_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_TEST_RESULT_LOW   = 8'h0c;
	localparam logic [7:0] ADDR_TEST_RESULT_HIGH  = 8'h0d;
	localparam logic [7:0] ADDR_EXPOSURE_LOW      = 8'h0e;
	localparam logic [7:0] ADDR_EXPOSURE_HIGH     = 8'h0f;
	localparam logic [7:0] ADDR_FRAME_PERIOD_LOW  = 8'h10;
	localparam logic [7:0] ADDR_FRAME_PERIOD_HIGH = 8'h11;
	localparam logic [7:0] ADDR_MOTION_ZERO       = 8'h12;
	localparam logic [7:0] ADDR_FIRMWARE_ENABLE   = 8'h14;

	// ---------------------------------------------------------------
	// Values and reset states
	// ---------------------------------------------------------------
	localparam logic [7:0]  FW_CRC_START       = 8'ha1;
	localparam logic [15:0] SELF_TEST_PASS     = 16'h1bbf;
	localparam logic [15:0] FW_CRC_PASS        = 16'hbeef;
	localparam logic [15:0] TEST_FAIL_VALUE    = 16'h0000;
	localparam logic [15:0] TEST_RESULT_RESET  = 16'h0000;
	localparam logic [15:0] EXPOSURE_RESET     = 16'h0085;
	localparam logic [15:0] FRAME_PERIOD_RESET = 16'h2ee0;
	localparam logic [7:0]  UNMAPPED_READ      = 8'h00;
	localparam int          EXPOSURE_STEP_SHIFT = 4;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ            = 20000;
	localparam int SELF_TEST_TIME_MS  = 200;
	localparam int FW_CRC_TIME_MS     = 7;
	localparam int SELF_TEST_CYCLES   = SELF_TEST_TIME_MS * CLK_KHZ;
	localparam int FW_CRC_CYCLES      = FW_CRC_TIME_MS * CLK_KHZ;

	// ---------------------------------------------------------------
	// Test sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TEST_IDLE      = 2'b00,
		TEST_SELF      = 2'b01,
		TEST_CRC_WAIT  = 2'b10,
		TEST_CRC_FRAME = 2'b11
	} srr_test_state_type;

endpackage : srr_pkg

// file: src/srr_exposure_ctl.sv
// Purpose: Per-frame automatic exposure adjustment
// Assumes: frameTick is a one-cycle pulse per frame
// Notes:   Step is one sixteenth; a step of zero leaves the value
`timescale 1ns/10ps
module srr_exposure_ctl
	import srr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	// Frame events and brightness
	input  wire logic             frameTick,
	input  wire logic             tooBright,
	input  wire logic             tooDark,
	// Control
	input  wire logic             gainControlDisable,
	input  wire logic [WIDTH-1:0] exposureMaxBound,
	// Result
	output logic      [WIDTH-1:0] exposure_q
);

	logic [WIDTH-1:0] step;
	logic [WIDTH:0]   upSum;
	logic [WIDTH-1:0] exposure_d;

	assign step  = exposure_q >> EXPOSURE_STEP_SHIFT;           // R13
	assign upSum = {1'b0, exposure_q} + {1'b0, step};

	always_comb begin
		exposure_d = exposure_q;
		if (gainControlDisable) begin
			exposure_d = exposureMaxBound;                        // R16
		end else if (frameTick) begin                             // R12
			if (tooBright) begin
				exposure_d = exposure_q - step;                   // R13
			end else if (tooDark) begin
				if (upSum > {1'b0, exposureMaxBound}) begin
					exposure_d = exposureMaxBound;                // R14
				end else begin
					exposure_d = upSum[WIDTH-1:0];
				end
			end
			if (exposure_d > exposureMaxBound) begin
				exposure_d = exposureMaxBound;                    // R14
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			exposure_q <= EXPOSURE_RESET[WIDTH-1:0];
		end else begin
			exposure_q <= exposure_d;
		end
	end

endmodule : srr_exposure_ctl

// file: src/srr_status_regs.sv
// Purpose: Test result, exposure, frame period and motion-zero registers
// Assumes: Serial engine gives one-cycle read and write strobes
// Notes:   Bound and config registers live outside this block
//
// Function
// R01: 16-bit test result at 0x0c/0x0d
// R02: Result bytes readable in either order
// R03: Self-test pass shows 0x1B, 0xBF
// R04: Firmware CRC pass shows 0xBE, 0xEF
// R05: Self-test starts on config bit
// R06: Hardware reset precedes self-test; contents lost
// R07: Firmware CRC starts on enable write
// R08: 0xA1 starts CRC; wait 7ms plus frame
// R09: Self-test 200ms, reloads defaults, port busy; here only frame period reloads, not exposure
// R10: Exposure readable at 0x0e/0x0f, read-only
// R11: Host reads exposure high then low
// R12: Exposure evaluated and adjusted every frame
// R13: Adjustment step is one sixteenth
// R14: Exposure never exceeds maximum bound; here clamped only at frame ticks or under gain disable
// R15: Host fixes exposure via gain disable
// R16: Gain disable holds exposure at bound
// R17: Frame period readable at 0x10/0x11
// R18: Host reads frame period high first
// R19: Host fixes rate via fixed-rate bit
// R20: Fixed rate takes period from bound
// R21: Frame rate is clock over period
// R22: Any write to 0x12 zeroes motion
// R23: Motion zero touches nothing else
// R24: High-byte read latches matching low byte
`timescale 1ns/10ps
module srr_status_regs
	import srr_pkg::*;
#(
	parameter int SELF_TEST_LEN = SELF_TEST_CYCLES,
	parameter int FW_CRC_LEN    = FW_CRC_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Register port from the serial engine
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	output logic      [7:0]  regRdData_q,
	output logic             regRdValid_q,
	// Configuration from the bound and config registers
	input  wire logic        selfTestReq,
	input  wire logic        gainControlDisable,
	input  wire logic        fixedRateSelect,
	input  wire logic [15:0] exposureMaxBound,
	input  wire logic [15:0] framePeriodMaxBound,
	input  wire logic [15:0] framePeriodMinBound,
	// Image statistics and test engines
	input  wire logic        tooBright,
	input  wire logic        tooDark,
	input  wire logic        selfTestPass,
	input  wire logic        fwCrcPass,
	// Effects
	output logic             motionZero_q,
	output logic             frameTick_q,
	output logic             testBusy_q,
	output logic             selfTestRun_q,
	output logic             fwCrcRun_q,
	output logic             defaultsLoad_q
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	srr_test_state_type testState_q;
	logic [31:0]        testCnt_q;
	logic [15:0]        testResult_q;
	logic [15:0]        exposure;
	logic [15:0]        framePeriod_q;
	logic [15:0]        framePeriod_d;
	logic [15:0]        frameCnt_q;
	logic [16:0]        autoSum;
	logic [7:0]         exposureLoLatch_q;
	logic [7:0]         framePeriodLoLatch_q;
	logic               crcStart;
	logic               motionHit;
	logic               selfTestDone;
	logic               crcWaitDone;
	logic               crcDone;

	assign crcStart  = regWrEn && (regAddr == ADDR_FIRMWARE_ENABLE)
		&& (regWrData == FW_CRC_START);                           // R07 R08
	assign motionHit = regWrEn && (regAddr == ADDR_MOTION_ZERO);

	// ---------------------------------------------------------------
	// Exposure control
	// ---------------------------------------------------------------
	srr_exposure_ctl #(
		.WIDTH              (16)
	) uExposure (
		.clk_sys            (clk_sys),
		.arst_n             (arst_n),
		.frameTick          (frameTick_q),
		.tooBright          (tooBright),
		.tooDark            (tooDark),
		.gainControlDisable (gainControlDisable),
		.exposureMaxBound   (exposureMaxBound),
		.exposure_q         (exposure)
	);

	// ---------------------------------------------------------------
	// Frame period choice
	// ---------------------------------------------------------------
	// Auto mode: shortest period that still fits the exposure
	assign autoSum = {1'b0, framePeriodMinBound} + {1'b0, exposure};

	always_comb begin
		if (fixedRateSelect) begin
			framePeriod_d = framePeriodMaxBound;                  // R20
		end else if (autoSum > {1'b0, framePeriodMaxBound}) begin
			framePeriod_d = framePeriodMaxBound;
		end else begin
			framePeriod_d = autoSum[15:0];
		end
	end

	// New period only at a frame boundary or on the defaults reload pulse
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			framePeriod_q <= FRAME_PERIOD_RESET;
		end else if (defaultsLoad_q) begin
			framePeriod_q <= FRAME_PERIOD_RESET;                  // R09
		end else if (frameTick_q) begin
			framePeriod_q <= framePeriod_d;
		end
	end

	// ---------------------------------------------------------------
	// Frame timer: one tick per period of clock cycles
	// ---------------------------------------------------------------
	// Counter and tick restart together, so a new period counts cleanly
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			frameCnt_q  <= 16'h0000;
			frameTick_q <= 1'b0;
		end else if (frameCnt_q + 16'h0001 >= framePeriod_q) begin
			frameCnt_q  <= 16'h0000;                              // R21
			frameTick_q <= 1'b1;
		end else begin
			frameCnt_q  <= frameCnt_q + 16'h0001;
			frameTick_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Test sequencer
	// ---------------------------------------------------------------
	// End conditions decoded once and shared by the state, counter, result and reload blocks
	assign selfTestDone = (testState_q == TEST_SELF)
		&& (testCnt_q + 32'h1 >= 32'(SELF_TEST_LEN));     // R09
	assign crcWaitDone  = (testState_q == TEST_CRC_WAIT)
		&& (testCnt_q + 32'h1 >= 32'(FW_CRC_LEN));        // R08
	assign crcDone      = (testState_q == TEST_CRC_FRAME) && frameTick_q;

	// State only; counter, result and reload pulse have their own blocks
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			testState_q <= TEST_IDLE;
		end else begin
			case (testState_q)
				TEST_IDLE: begin
					if (selfTestReq) begin
						testState_q <= TEST_SELF;                 // R05 R06
					end else if (crcStart) begin
						testState_q <= TEST_CRC_WAIT;             // R07
					end
				end
				TEST_SELF: begin
					if (selfTestDone) begin
						testState_q <= TEST_IDLE;                 // R09
					end
				end
				TEST_CRC_WAIT: begin
					if (crcWaitDone) begin
						testState_q <= TEST_CRC_FRAME;            // R08
					end
				end
				TEST_CRC_FRAME: begin
					if (crcDone) begin
						testState_q <= TEST_IDLE;                 // R08
					end
				end
				default: begin
					testState_q <= TEST_IDLE;
				end
			endcase
		end
	end

	// Counts the timed phases only; cleared whenever the sequencer idles
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			testCnt_q <= 32'h0000_0000;
		end else if ((testState_q == TEST_SELF && !selfTestDone)
			|| (testState_q == TEST_CRC_WAIT && !crcWaitDone)) begin
			testCnt_q <= testCnt_q + 32'h1;
		end else if (testState_q == TEST_IDLE) begin
			testCnt_q <= 32'h0000_0000;
		end
	end

	// Result changes only as a test ends, so no half-done value shows
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			testResult_q <= TEST_RESULT_RESET;
		end else if (selfTestDone) begin
			testResult_q <= selfTestPass ? SELF_TEST_PASS
				: TEST_FAIL_VALUE;                                // R03
		end else if (crcDone) begin
			testResult_q <= fwCrcPass ? FW_CRC_PASS
				: TEST_FAIL_VALUE;                                // R04
		end
	end

	// One-cycle reload pulse as the self-test hands back the port
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			defaultsLoad_q <= 1'b0;
		end else begin
			defaultsLoad_q <= selfTestDone;                       // R09
		end
	end

	// Port is off limits while either test runs
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			testBusy_q    <= 1'b0;
			selfTestRun_q <= 1'b0;
			fwCrcRun_q    <= 1'b0;
		end else begin
			selfTestRun_q <= (testState_q == TEST_SELF);          // R09
			fwCrcRun_q    <= (testState_q == TEST_CRC_WAIT)
				|| (testState_q == TEST_CRC_FRAME);
			testBusy_q    <= (testState_q != TEST_IDLE);          // R09
		end
	end

	// ---------------------------------------------------------------
	// Motion zero strobe
	// ---------------------------------------------------------------
	// Pulse only; no state of this block is touched by the write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			motionZero_q <= 1'b0;
		end else begin
			motionZero_q <= motionHit;                            // R22 R23
		end
	end

	// ---------------------------------------------------------------
	// Low-byte shadows
	// ---------------------------------------------------------------
	// Low byte can move between two serial reads; freeze it on high read
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			exposureLoLatch_q    <= EXPOSURE_RESET[7:0];
			framePeriodLoLatch_q <= FRAME_PERIOD_RESET[7:0];
		end else if (regRdEn) begin
			if (regAddr == ADDR_EXPOSURE_HIGH) begin
				exposureLoLatch_q <= exposure[7:0];               // R24 R11
			end else if (regAddr == ADDR_FRAME_PERIOD_HIGH) begin
				framePeriodLoLatch_q <= framePeriod_q[7:0];       // R24 R18
			end
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Unmapped reads give zero rather than a stale byte
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			regRdData_q  <= UNMAPPED_READ;
			regRdValid_q <= 1'b0;
		end else begin
			regRdValid_q <= regRdEn;
			if (regRdEn) begin
				if (regAddr == ADDR_TEST_RESULT_LOW) begin
					regRdData_q <= testResult_q[7:0];             // R01 R02
				end else if (regAddr == ADDR_TEST_RESULT_HIGH) begin
					regRdData_q <= testResult_q[15:8];            // R01 R02
				end else if (regAddr == ADDR_EXPOSURE_LOW) begin
					regRdData_q <= exposureLoLatch_q;             // R10
				end else if (regAddr == ADDR_EXPOSURE_HIGH) begin
					regRdData_q <= exposure[15:8];                // R10
				end else if (regAddr == ADDR_FRAME_PERIOD_LOW) begin
					regRdData_q <= framePeriodLoLatch_q;          // R17
				end else if (regAddr == ADDR_FRAME_PERIOD_HIGH) begin
					regRdData_q <= framePeriod_q[15:8];           // R17
				end else begin
					regRdData_q <= UNMAPPED_READ;
				end
			end
		end
	end

endmodule : srr_status_regs

// file: verification/srr_status_regs_checker.sv
// Purpose: Port checks for the status readback registers
// Assumes: One clock domain, reset arst_n
// Notes:   Cycle figures follow the hand-over timing
`timescale 1ns/10ps
module srr_status_regs_checker
	import srr_pkg::*;
#(
	parameter int SELF_TEST_LEN = 20
) (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       arst_n,
	// Register port
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData_q,
	input wire logic       regRdValid_q,
	// Tests and effects
	input wire logic       selfTestReq,
	input wire logic       motionZero_q,
	input wire logic       testBusy_q,
	input wire logic       selfTestRun_q,
	input wire logic       fwCrcRun_q,
	input wire logic       defaultsLoad_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [31:0] runCnt_q;
	logic        idle;
	assign idle = !testBusy_q && !selfTestRun_q && !fwCrcRun_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			runCnt_q <= '0;
		end else begin
			runCnt_q <= selfTestRun_q ? runCnt_q + 32'd1 : '0;
		end
	end
	sequence motionPulse;
		motionZero_q ##1 !motionZero_q;
	endsequence
	sequence crcEnter;
		!fwCrcRun_q ##1 (fwCrcRun_q && testBusy_q);
	endsequence
	rd_answer_a: assert property (regRdEn |=> regRdValid_q)
		else $error("read gave no valid pulse");
	rd_quiet_a: assert property (!regRdEn |=> !regRdValid_q)
		else $error("valid pulse without read");
	unmapped_rd_a: assert property (regRdEn && regAddr == 8'h13
		|=> regRdData_q == UNMAPPED_READ) else $error("unmapped read");
	motion_pulse_a: assert property (regWrEn &&
		regAddr == ADDR_MOTION_ZERO |=> motionPulse) else $error("no zero");
	motion_cause_a: assert property (motionZero_q |-> $past(regWrEn)
		&& $past(regAddr) == ADDR_MOTION_ZERO) else $error("stray zero");
	crc_start_a: assert property (regWrEn && idle && !selfTestReq &&
		regAddr == ADDR_FIRMWARE_ENABLE && regWrData == FW_CRC_START
		|=> crcEnter) else $error("crc did not start");
	self_start_a: assert property (selfTestReq && idle
		|=> ##1 selfTestRun_q) else $error("self-test did not start");
	self_len_a: assert property (runCnt_q <= SELF_TEST_LEN + 1)
		else $error("self-test too long");
	self_end_a: assert property ($fell(selfTestRun_q)
		|-> $past(defaultsLoad_q)) else $error("no defaults reload");
endmodule : srr_status_regs_checker

bind srr_status_regs srr_status_regs_checker #(
	.SELF_TEST_LEN(SELF_TEST_LEN)
) i_chk (.clk_sys, .arst_n, .regWrEn, .regRdEn, .regAddr, .regWrData,
	.regRdData_q, .regRdValid_q, .selfTestReq, .motionZero_q,
	.testBusy_q, .selfTestRun_q, .fwCrcRun_q, .defaultsLoad_q);

// file: verification/srr_host_model.sv
// Purpose: Serial-master side of the register port
// Assumes: One access per wr or rd call, driven on rising edges
// Notes:   Released lines show the inverse, never the last value
`timescale 1ns/10ps
module srr_host_model (
	// Clock
	input  wire logic       clk_sys,
	// Register port towards the block
	output logic            regWrEn,
	output logic            regRdEn,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	input  wire logic [7:0] regRdData_q
);
	initial begin
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
		regAddr   = 8'h00;
		regWrData = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrEn   <= 1'b0;
		regAddr   <= ~a;
		regWrData <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		@(negedge clk_sys);
		d = regRdData_q;
	endtask : rd
	// High byte first, low byte next with nothing between
	task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
		rd(hi, v[15:8]);
		rd(hi - 8'h01, v[7:0]);
	endtask : rd16
endmodule : srr_host_model

// file: verification/srr_status_regs_test.sv
// Purpose: Directed test of the status readback registers
// Assumes: Shortened test lengths, fixed frame period 0x0e7e, then auto period
// Notes:   Expected values come from the step and clamp rules
`timescale 1ns/10ps
module srr_status_regs_test
	import srr_pkg::*;
;
	logic        clk_sys, arst_n, regWrEn, regRdEn, regRdValid_q;
	logic        selfTestReq, gainControlDisable, fixedRateSelect;
	logic        tooBright, tooDark, selfTestPass, fwCrcPass, up, pass;
	logic        motionZero_q, frameTick_q, testBusy_q, selfMode;
	logic        selfTestRun_q, fwCrcRun_q, defaultsLoad_q;
	logic [7:0]  regAddr, regWrData, regRdData_q;
	logic [15:0] exposureMaxBound, framePeriodMaxBound;
	logic [15:0] framePeriodMinBound, v, e, expv;
	int          checks, error_cnt, gap;
	srr_status_regs #(.SELF_TEST_LEN(20), .FW_CRC_LEN(10)) i_dut (
		.clk_sys, .arst_n, .regWrEn, .regRdEn, .regAddr, .regWrData,
		.regRdData_q, .regRdValid_q, .selfTestReq, .gainControlDisable,
		.fixedRateSelect, .exposureMaxBound, .framePeriodMaxBound,
		.framePeriodMinBound, .tooBright, .tooDark, .selfTestPass,
		.fwCrcPass, .motionZero_q, .frameTick_q, .testBusy_q,
		.selfTestRun_q, .fwCrcRun_q, .defaultsLoad_q);
	srr_host_model i_host (.clk_sys, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData_q);
	always #25 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [15:0] x,
		input logic [15:0] got);
		checks++;
		if (got !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, x, got);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	task automatic reset;
		arst_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
	endtask : reset
	// Bounded wait until a signal reads the wanted level
	task automatic waitFor(ref logic s, input logic lvl);
		int n;
		n = 0;
		while (s !== lvl && n < 20000) begin
			@(negedge clk_sys);
			n++;
		end
		check("wait", lvl, s);
	endtask : waitFor
	initial begin
		repeat (90000) @(posedge clk_sys);
		error_cnt++;
		end_sim();
	end
	initial begin
		{clk_sys, arst_n, selfTestReq, gainControlDisable} = 4'h0;
		{tooBright, tooDark, selfTestPass, fwCrcPass} = 4'h3;
		fixedRateSelect     = 1'b1;
		exposureMaxBound    = 16'h1000;
		framePeriodMaxBound = 16'h0e7e;
		framePeriodMinBound = 16'h0100;
		reset();
		i_host.rd16(ADDR_EXPOSURE_HIGH, v);
		check("exposure reset", EXPOSURE_RESET, v);
		@(posedge clk_sys);
		gainControlDisable <= 1'b1;
		i_host.wr(ADDR_MOTION_ZERO, 8'h5a);
		i_host.wr(ADDR_EXPOSURE_LOW, 8'h00);
		i_host.rd16(ADDR_EXPOSURE_HIGH, v);
		check("exposure held", 16'h1000, v);
		i_host.rd(8'h13, v[7:0]);
		check("unmapped", UNMAPPED_READ, v[7:0]);
		$display("test held exposure done");
		@(posedge clk_sys);
		exposureMaxBound   <= 16'h1100;
		gainControlDisable <= 1'b0;
		e = 16'h1000;
		for (int i = 0; i < 5; i++) begin
			up = (i > 0);
			@(posedge clk_sys);
			tooBright <= !up;
			tooDark   <= up;
			waitFor(frameTick_q, 1'b1);
			e = up ? e + (e >> EXPOSURE_STEP_SHIFT) : e - (e >> 4);
			e = (e > 16'h1100) ? 16'h1100 : e;
			i_host.rd16(ADDR_EXPOSURE_HIGH, v);
			check("exposure step", e, v);
		end
		i_host.rd16(ADDR_FRAME_PERIOD_HIGH, v);
		check("frame period", 16'h0e7e, v);
		waitFor(frameTick_q, 1'b1);
		@(negedge clk_sys);
		gap = 1;
		while (frameTick_q !== 1'b1 && gap < 20000) begin
			@(negedge clk_sys);
			gap++;
		end
		check("tick spacing", 16'h0e7e, 16'(gap));
		@(posedge clk_sys);
		fixedRateSelect     <= 1'b0;
		framePeriodMaxBound <= 16'h2000;
		@(negedge clk_sys);
		waitFor(frameTick_q, 1'b1);
		i_host.rd16(ADDR_FRAME_PERIOD_HIGH, v);
		check("auto period", 16'h0100 + 16'h1100, v);
		$display("test auto exposure done");
		for (int k = 0; k < 4; k++) begin
			selfMode = (k < 2);
			pass = !k[0];
			@(posedge clk_sys);
			selfTestPass <= pass;
			fwCrcPass    <= pass;
			if (selfMode) begin
				reset();
				@(posedge clk_sys);
				selfTestReq <= 1'b1;
				@(posedge clk_sys);
				selfTestReq <= 1'b0;
			end else begin
				i_host.wr(ADDR_FIRMWARE_ENABLE, FW_CRC_START);
			end
			waitFor(testBusy_q, 1'b1);
			waitFor(testBusy_q, 1'b0);
			expv = selfMode ? SELF_TEST_PASS : FW_CRC_PASS;
			expv = pass ? expv : TEST_FAIL_VALUE;
			i_host.rd(ADDR_TEST_RESULT_LOW, v[7:0]);
			i_host.rd(ADDR_TEST_RESULT_HIGH, v[15:8]);
			check("result low first", expv, v);
			i_host.rd(ADDR_TEST_RESULT_HIGH, v[15:8]);
			i_host.rd(ADDR_TEST_RESULT_LOW, v[7:0]);
			check("result high first", expv, v);
			$display("test result case %0d done", k);
		end
		end_sim();
	end
endmodule : srr_status_regs_test
